// [hw/masr_pkg.sv]
package masr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    localparam int unsigned ADR_W = 13;
    localparam logic [10:0] IDX_PHASE = 11'h210;
    localparam logic [10:0] IDX_SPEED = 11'h216;
    localparam logic [10:0] IDX_CURRENT = 11'h410;
    localparam logic [ADR_W-1:0] ADDR_PHASE = {IDX_PHASE, 2'b00};
    localparam logic [ADR_W-1:0] ADDR_SPEED = {IDX_SPEED, 2'b00};
    localparam logic [ADR_W-1:0] ADDR_CURRENT = {IDX_CURRENT, 2'b00};

    localparam int unsigned DATA_W = 32;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PHASE_READ_MASK = 32'h0000_ffff;

    // Word slots held by the word registers
    localparam int unsigned WORD_COUNT = 3;
    localparam int unsigned WORD_PHASE = 0;
    localparam int unsigned WORD_SPEED = 1;
    localparam int unsigned WORD_CURRENT = 2;

    // ------------------------------------------------------------
    // Motor phase codes
    // ------------------------------------------------------------
    localparam int unsigned PHASE_CODE_W = 5;
    localparam logic [PHASE_CODE_W-1:0] PHASE_IDLE = 5'h00;
    localparam logic [PHASE_CODE_W-1:0] PHASE_CL_ALIGNED = 5'h09;
    localparam logic [PHASE_CODE_W-1:0] PHASE_ACTIVE_BRAKING = 5'h0a;
    localparam logic [PHASE_CODE_W-1:0] PHASE_MOTOR_FAULT = 5'h0e;
    localparam logic [PHASE_CODE_W-1:0] PHASE_EXTR_STOP_CHECK = 5'h0f;
    localparam logic [PHASE_CODE_W-1:0] PHASE_EXTR_DONE = 5'h17;
    localparam logic [PHASE_CODE_W-1:0] PHASE_EXTR_FAULT = 5'h18;

    // Fixed-point scale of speed and current words
    localparam int unsigned SCALE_FRAC_BITS = 27;

endpackage : masr_pkg

// [hw/masr_upd_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface masr_upd_if;
    logic valid;
    logic [31:0] data;

    modport src (
        output valid,
        output data
    );
    modport dst (
        input valid,
        input data
    );
endinterface : masr_upd_if

`default_nettype wire

// [hw/masr_word_reg.sv]
`timescale 1ns/1ps
`default_nettype none

module masr_word_reg
    import masr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    masr_upd_if.dst upd_dst,
    output logic [DATA_W-1:0] value_out
);

    // ------------------------------------------------------------
    // Whole-word capture
    // ------------------------------------------------------------
    // One edge loads all 32 bits, so no reader sees a torn value
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            value_out <= WORD_RESET;
        end else if (upd_dst.valid) begin
            value_out <= upd_dst.data;
        end
    end

endmodule : masr_word_reg

`default_nettype wire

// [hw/masr_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The phase word sits at index 0x210, resets to zero, code in 15-0.
// - Phase codes 0x0 to 0x9 cover idle through closed loop aligned.
// - Phase codes 0xA to 0xE cover braking, stops and the motor fault.
// - Phase codes 0xF to 0x18 cover parameter extraction steps.
// - The pulse speed word sits at index 0x216, 32 bits, resets to zero.
// - The speed word is raw Q27 of full-scale speed, kept unaltered.
// - The supply current word sits at index 0x410, resets to zero.
// - The current word is raw Q27 times 1.25 A, kept unaltered.
// - Software writes are acknowledged but never change any word.
module masr_status_regs
    import masr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [DATA_W-1:0] wb_dat_in,
    output logic [DATA_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic phase_valid_in,
    input wire logic [PHASE_CODE_W-1:0] phase_code_in,
    input wire logic speed_valid_in,
    input wire logic [DATA_W-1:0] speed_value_in,
    input wire logic current_valid_in,
    input wire logic [DATA_W-1:0] current_value_in,
    output logic motor_fault_out,
    output logic extraction_active_out,
    output logic write_ignored_out
);

    // ------------------------------------------------------------
    // Update sources from the control algorithm
    // ------------------------------------------------------------
    logic [WORD_COUNT-1:0] src_valid;
    logic [DATA_W-1:0] src_data [WORD_COUNT];
    logic [DATA_W-1:0] word_val [WORD_COUNT];
    logic phase_code_ok;

    // Codes past the last defined one are dropped, old phase stays
    assign phase_code_ok = (phase_code_in <= PHASE_EXTR_FAULT);

    always_comb begin
        src_valid[WORD_PHASE] = phase_valid_in && phase_code_ok;
        src_data[WORD_PHASE] = {{(DATA_W-PHASE_CODE_W){1'b0}},
                                phase_code_in};
        // Raw fixed-point words; scaling is done by software
        src_valid[WORD_SPEED] = speed_valid_in;
        src_data[WORD_SPEED] = speed_value_in;
        src_valid[WORD_CURRENT] = current_valid_in;
        src_data[WORD_CURRENT] = current_value_in;
    end

    // ------------------------------------------------------------
    // Word registers
    // ------------------------------------------------------------
    masr_upd_if upd [WORD_COUNT] ();

    genvar gi;
    generate
        for (gi = 0; gi < WORD_COUNT; gi++) begin : g_word
            assign upd[gi].valid = src_valid[gi];
            assign upd[gi].data = src_data[gi];
            masr_word_reg u_word (
                .clk_in(mclk_in),
                .rst_in(sys_rst_in),
                .upd_dst(upd[gi]),
                .value_out(word_val[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------
    logic bus_req;
    logic [DATA_W-1:0] rd_next;
    logic [PHASE_CODE_W-1:0] phase_now;

    // One wait state: ack rises the cycle after the request
    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign phase_now = word_val[WORD_PHASE][PHASE_CODE_W-1:0];

    always_comb begin
        rd_next = UNMAPPED_READ;
        if (wb_adr_in[1:0] == 2'b00) begin
            case (wb_adr_in[ADR_W-1:2])
                IDX_PHASE: begin
                    rd_next = word_val[WORD_PHASE] & PHASE_READ_MASK;
                end
                IDX_SPEED: begin
                    rd_next = word_val[WORD_SPEED];
                end
                IDX_CURRENT: begin
                    rd_next = word_val[WORD_CURRENT];
                end
                default: begin
                    rd_next = UNMAPPED_READ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req;
        end
    end

    // Whole word taken in one edge, never two halves
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_dat_out <= WORD_RESET;
        end else if (bus_req && !wb_we_in) begin
            wb_dat_out <= rd_next;
        end
    end

    // Writes touch nothing; a pulse flags the discarded write
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            write_ignored_out <= 1'b0;
        end else begin
            write_ignored_out <= bus_req && wb_we_in;
        end
    end

    // ------------------------------------------------------------
    // Phase-derived indications
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            motor_fault_out <= 1'b0;
        end else begin
            motor_fault_out <= (phase_now == PHASE_MOTOR_FAULT) ||
                               (phase_now == PHASE_EXTR_FAULT);
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            extraction_active_out <= 1'b0;
        end else begin
            extraction_active_out <= (phase_now >= PHASE_EXTR_STOP_CHECK) &&
                                     (phase_now <= PHASE_EXTR_DONE);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence rd_start(logic [ADR_W-1:0] a);
        bus_req && !wb_we_in && wb_adr_in == a;
    endsequence

    sequence wr_start;
        bus_req && wb_we_in && !phase_valid_in && !speed_valid_in &&
            !current_valid_in;
    endsequence

    sequence one_ack;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    sequence wr_req;
        bus_req && wb_we_in;
    endsequence

    sequence rd_other;
        bus_req && !wb_we_in && wb_adr_in != ADDR_PHASE &&
            wb_adr_in != ADDR_SPEED && wb_adr_in != ADDR_CURRENT;
    endsequence

    bus_ack_timing_a: assert property (
        bus_req |=> one_ack)
        else $error("ack not one cycle after request");

    phase_high_zero_a: assert property (
        rd_start(ADDR_PHASE) |=> wb_ack_out && wb_dat_out[31:16] == 16'h0)
        else $error("phase word upper half not zero");

    run_codes_load_a: assert property (
        phase_valid_in && phase_code_in <= PHASE_CL_ALIGNED |=>
            phase_now == $past(phase_code_in))
        else $error("run phase code not loaded");

    stop_codes_load_a: assert property (
        phase_valid_in && phase_code_in >= PHASE_ACTIVE_BRAKING &&
        phase_code_in <= PHASE_MOTOR_FAULT |=>
            phase_now == $past(phase_code_in) ##1 motor_fault_out ==
            ($past(phase_now) == PHASE_MOTOR_FAULT))
        else $error("stop phase code not loaded");

    extr_codes_load_a: assert property (
        phase_valid_in && phase_code_in >= PHASE_EXTR_STOP_CHECK |=>
            ($past(phase_code_in) <= PHASE_EXTR_FAULT ?
                 phase_now == $past(phase_code_in)
               : $stable(word_val[WORD_PHASE])))
        else $error("extraction code handling wrong");

    speed_read_a: assert property (
        rd_start(ADDR_SPEED) |=> wb_dat_out == $past(word_val[WORD_SPEED]))
        else $error("speed read mismatch");

    speed_raw_keep_a: assert property (
        speed_valid_in |=> word_val[WORD_SPEED] == $past(speed_value_in))
        else $error("speed word not loaded raw");

    current_read_a: assert property (
        rd_start(ADDR_CURRENT) |=>
            wb_dat_out == $past(word_val[WORD_CURRENT]))
        else $error("current read mismatch");

    current_raw_keep_a: assert property (
        current_valid_in |=> word_val[WORD_CURRENT] == $past(current_value_in))
        else $error("current word not loaded raw");

    write_no_effect_a: assert property (
        wr_start |=> $stable(word_val[WORD_PHASE]) &&
            $stable(word_val[WORD_SPEED]) &&
            $stable(word_val[WORD_CURRENT]) && write_ignored_out)
        else $error("software write altered a word");

    coherent_read_a: assert property (
        rd_start(ADDR_PHASE) ##1 wb_ack_out |->
            wb_dat_out == ($past(word_val[WORD_PHASE]) & PHASE_READ_MASK))
        else $error("phase read not one whole word");

    ack_needs_req_a: assert property (
        !bus_req |=> !wb_ack_out)
        else $error("ack without a taken request");

    read_data_hold_a: assert property (
        !(bus_req && !wb_we_in) |=> $stable(wb_dat_out))
        else $error("read data moved without a read");

    write_keeps_data_a: assert property (
        wr_req |=> $stable(wb_dat_out) && write_ignored_out)
        else $error("write disturbed read data");

    no_write_flag_a: assert property (
        !(bus_req && wb_we_in) |=> !write_ignored_out)
        else $error("write flag without a write");

    flag_with_ack_a: assert property (
        write_ignored_out |-> wb_ack_out)
        else $error("write flag outside the ack cycle");

    phase_hold_a: assert property (
        !phase_valid_in |=> $stable(word_val[WORD_PHASE]))
        else $error("phase word moved with no update");

    speed_hold_a: assert property (
        !speed_valid_in |=> $stable(word_val[WORD_SPEED]))
        else $error("speed word moved with no update");

    current_hold_a: assert property (
        !current_valid_in |=> $stable(word_val[WORD_CURRENT]))
        else $error("current word moved with no update");

    phase_range_a: assert property (
        word_val[WORD_PHASE] <= PHASE_EXTR_FAULT)
        else $error("phase word holds an undefined code");

    unmapped_zero_a: assert property (
        rd_other |=> wb_dat_out == UNMAPPED_READ)
        else $error("unmapped read not zero");

    misaligned_zero_a: assert property (
        bus_req && !wb_we_in && wb_adr_in[1:0] != 2'b00 |=>
            wb_dat_out == UNMAPPED_READ)
        else $error("misaligned read not zero");

    phase_read_a: assert property (
        rd_start(ADDR_PHASE) |=>
            wb_dat_out[PHASE_CODE_W-1:0] == $past(phase_now))
        else $error("phase read code mismatch");

    fault_flag_a: assert property (
        motor_fault_out == ($past(phase_now) == PHASE_MOTOR_FAULT ||
                            $past(phase_now) == PHASE_EXTR_FAULT))
        else $error("fault indication wrong");

    extr_flag_a: assert property (
        extraction_active_out ==
            ($past(phase_now) >= PHASE_EXTR_STOP_CHECK &&
             $past(phase_now) <= PHASE_EXTR_DONE))
        else $error("extraction indication wrong");

    // ------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------
    // Reset itself is the antecedent, so these run with no disable
    phase_reset_a: assert property (disable iff (1'b0)
        sys_rst_in |=> word_val[WORD_PHASE] == WORD_RESET)
        else $error("phase word not cleared by reset");

    speed_reset_a: assert property (disable iff (1'b0)
        sys_rst_in |=> word_val[WORD_SPEED] == WORD_RESET)
        else $error("speed word not cleared by reset");

    current_reset_a: assert property (disable iff (1'b0)
        sys_rst_in |=> word_val[WORD_CURRENT] == WORD_RESET)
        else $error("current word not cleared by reset");

    outputs_reset_a: assert property (disable iff (1'b0)
        sys_rst_in |=> !wb_ack_out && !write_ignored_out &&
            !motor_fault_out && !extraction_active_out &&
            wb_dat_out == WORD_RESET)
        else $error("outputs not cleared by reset");

endmodule : masr_status_regs

`default_nettype wire

// [testbench/masr_status_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none

module masr_status_regs_test import masr_pkg::*;;

    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [DATA_W-1:0] wdat = '0;
    logic [DATA_W-1:0] rdat;
    logic ack;
    logic fault;
    logic extr;
    logic wign;
    logic pv = 1'b0;
    logic sv = 1'b0;
    logic cv = 1'b0;
    logic [4:0] pc = '0;
    logic [31:0] sval = '0;
    logic [31:0] cval = '0;
    logic [31:0] got;
    logic wi;
    logic [ADR_W-1:0] wa [4];
    logic [31:0] wexp [4];
    int n_fail = 0;
    int total_checks = 0;

    always #5 mclk_in = ~mclk_in;

    masr_status_regs uut (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .wb_cyc_in(cyc),
        .wb_stb_in(stb),
        .wb_we_in(we),
        .wb_adr_in(adr),
        .wb_sel_in(4'hf),
        .wb_dat_in(wdat),
        .wb_dat_out(rdat),
        .wb_ack_out(ack),
        .phase_valid_in(pv),
        .phase_code_in(pc),
        .speed_valid_in(sv),
        .speed_value_in(sval),
        .current_valid_in(cv),
        .current_value_in(cval),
        .motor_fault_out(fault),
        .extraction_active_out(extr),
        .write_ignored_out(wign)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task end_of_test;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task chkb(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : chkb

    // Called right after a rising edge; ends on the edge after release
    task bus(input logic w, input logic [ADR_W-1:0] a,
             output logic [31:0] d, output logic wig);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= 32'hffff_ffff;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_in);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_of_test();
        end
        d = rdat;
        wig = wign;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_in);
    endtask : bus

    task rd_chk(input logic [ADR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, got, wi);
        check(got, exp);
    endtask : rd_chk

    // Kind 0 phase, 1 speed, 2 current; one-cycle valid pulse
    task upd(input int k, input logic [31:0] v);
        pv <= (k == 0);
        sv <= (k == 1);
        cv <= (k == 2);
        pc <= v[4:0];
        sval <= v;
        cval <= v;
        @(posedge mclk_in);
        pv <= 1'b0;
        sv <= 1'b0;
        cv <= 1'b0;
    endtask : upd

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        wa = '{ADDR_PHASE, ADDR_SPEED, ADDR_CURRENT, ADDR_PHASE};
        wexp = '{32'h18, 32'hffff_0000, 32'h0a5a_5a5f, 32'h18};
        repeat (20) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        rd_chk(ADDR_PHASE, 32'h0);
        rd_chk(ADDR_SPEED, 32'h0);
        rd_chk(ADDR_CURRENT, 32'h0);
        $display("test reset values done");
        for (int i = 0; i <= 24; i++) begin
            upd(0, 32'(i));
            rd_chk(ADDR_PHASE, 32'(i));
            chkb(fault, i == 14 || i == 24);
            chkb(extr, i >= 15 && i <= 23);
        end
        // Out-of-range code must not disturb the held phase
        upd(0, 32'h19);
        rd_chk(ADDR_PHASE, 32'h18);
        $display("test phase codes done");
        upd(1, 32'h8000_0001);
        rd_chk(ADDR_SPEED, 32'h8000_0001);
        upd(1, 32'hffff_0000);
        rd_chk(ADDR_SPEED, 32'hffff_0000);
        upd(2, 32'h0a5a_5a5f);
        rd_chk(ADDR_CURRENT, 32'h0a5a_5a5f);
        $display("test raw words done");
        for (int j = 0; j < 4; j++) begin
            bus(1'b1, wa[j], got, wi);
            chkb(wi, 1'b1);
            chkb(ack, 1'b0);
            rd_chk(wa[j], wexp[j]);
            chkb(wign, 1'b0);
        end
        rd_chk(13'h0841, 32'h0);
        rd_chk(13'h0844, 32'h0);
        $display("test writes and unmapped done");
        sys_rst_in <= 1'b1;
        @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        rd_chk(ADDR_SPEED, 32'h0);
        rd_chk(ADDR_PHASE, 32'h0);
        chkb(fault, 1'b0);
        $display("test second reset done");
        end_of_test();
    end

endmodule : masr_status_regs_test

`default_nettype wire
